// [mbpm_drive_end.sv]
// drive end: parameter mailbox in holding registers with job engine
`timescale 1ns/1ps

// Functional notes
// - controller starts job: write-multiple at base, control 1
// - register two: function 2Fh, request byte length
// - register three: reference, id 1 read 2 write
// - register four: object id and parameter count
// - register five: attribute 10h and element count
// - registers six, seven: parameter number, subindex
// - write: ten registers, length 16, value high first
// - controller fetches result by read at base
// - mailbox read answers 20h bytes, sixteen registers
// - completion: control 2, 2Fh with response length
// - read success mirrors reference, response id 1
// - write success: id 2, content ends register four
// - read success: format/count, then value register six
// - in progress: control 1, 2F00h, error 0004h
// - errors: control 2, length 0, error code
// - control 0 means mailbox still being filled
module mbpm_drive_end #(
	parameter int PARAM_DEPTH = 16,
	parameter int JOB_CYCLES  = mbpm_pkg::JOB_CYCLES
) (
	input  wire logic        clk,
	input  wire logic        nrst,
	mbpm_link_if.dev         link,
	input  wire logic        drive_locked,
	output logic             job_busy
);
	import mbpm_pkg::*;

	localparam int PIDX_W = (PARAM_DEPTH > 1) ? $clog2(PARAM_DEPTH) : 1;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef enum logic [1:0] {D_IDLE, D_WRITE, D_ACK, D_READ} mbpm_dst_t;

	typedef struct packed {
		mbpm_dst_t                       st;
		logic [4:0]                      widx;
		logic [4:0]                      wcount;
		logic                            exc_pend;
		mbpm_word_t [MBOX_WORDS-1:0]     mbox;
		logic [PARAM_DEPTH-1:0][31:0]    params;
		logic [PARAM_DEPTH-1:0][7:0]     fmts;
		logic                            job_active;
		logic [15:0]                     timer;
		logic                            job_write;
		logic [7:0]                      job_ref;
		mbpm_word_t                      job_obj;
		logic [PIDX_W-1:0]               job_pidx;
		logic [7:0]                      job_fmt;
		logic [31:0]                     job_value;
		logic                            req_ready;
		logic                            rsp_valid;
		mbpm_word_t                      rsp_data;
		logic [7:0]                      rsp_byte_count;
		logic                            rsp_last;
		logic                            rsp_exc;
		logic                            job_busy;
	} mbpm_dev_state_t;

	mbpm_dev_state_t s;
	mbpm_dev_state_t next_s;

	// ------------------------------------------------------------
	// request check, returns the error code or zero
	// ------------------------------------------------------------
	function automatic mbpm_word_t job_check(input mbpm_word_t [MBOX_WORDS-1:0] mb, input logic locked);
		logic [7:0] id;
		logic [7:0] len;
		id  = mb[REG_REF_ID][7:0];
		len = mb[REG_FUNC_LEN][7:0];
		if (mb[REG_FUNC_LEN][15:8] != JOB_FUNC)
			return ERR_FUNC;
		if (id == REQ_ID_READ) begin
			if (len != LEN_READ_REQ)
				return ERR_LENGTH;
		end else if (id == REQ_ID_WRITE) begin
			if (len != LEN_WRITE_REQ)
				return ERR_LENGTH;
			if (locked)
				return ERR_STATE;
		end else begin
			return ERR_INTERNAL;
		end
		// only single value access to the parameter value is served
		if (mb[REG_ATTR_ELEM] != {ATTR_VALUE, COUNT_ONE})
			return ERR_INTERNAL;
		if (mb[REG_OBJ_COUNT][7:0] != COUNT_ONE)
			return ERR_INTERNAL;
		if (32'(mb[REG_PNUM]) >= PARAM_DEPTH)
			return ERR_INTERNAL;
		return ERR_NONE;
	endfunction

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		mbpm_word_t err;
		err = ERR_NONE;
		next_s = s;
		next_s.rsp_valid = 1'b0;
		next_s.rsp_last = 1'b0;
		next_s.rsp_exc = 1'b0;
		next_s.rsp_byte_count = 8'h00;
		next_s.rsp_data = 16'h0000;

		unique case (s.st)
			D_IDLE: begin
				next_s.req_ready = 1'b1;
				if (link.req_valid && s.req_ready) begin
					next_s.req_ready = 1'b0;
					next_s.widx = 5'd0;
					next_s.exc_pend = 1'b0;
					if (link.req_addr != MBOX_BASE) begin
						next_s.exc_pend = 1'b1;
						next_s.st = D_ACK;
					end else if (link.req_fc == FC_WRITE_MULTI && link.req_count != 8'h00
							&& link.req_count <= 8'(MBOX_WORDS)) begin
						next_s.wcount = 5'(link.req_count);
						next_s.st = D_WRITE;
					end else if (link.req_fc == FC_READ_HOLD) begin
						next_s.st = D_READ;
					end else begin
						next_s.exc_pend = 1'b1;
						next_s.st = D_ACK;
					end
				end
			end
			D_WRITE: begin
				// words land in order from the base, one per accepted beat
				if (link.wr_valid) begin
					next_s.mbox[s.widx[3:0]] = link.wr_data;
					next_s.widx = s.widx + 5'd1;
					if (s.widx == s.wcount - 5'd1)
						next_s.st = D_ACK;
				end
			end
			D_ACK: begin
				next_s.rsp_valid = 1'b1;
				next_s.rsp_last = 1'b1;
				next_s.rsp_exc = s.exc_pend;
				next_s.st = D_IDLE;
				// control 0 leaves the block alone while it is filled; a
				// second activation during a running job is ignored
				if (!s.exc_pend && !s.job_active
						&& s.mbox[REG_CONTROL] == CTRL_ACTIVE) begin
					err = job_check(s.mbox, drive_locked);
					if (err != ERR_NONE) begin
						next_s.mbox[REG_CONTROL] = CTRL_DONE;
						next_s.mbox[REG_FUNC_LEN] = {JOB_FUNC, LEN_ERROR};
						next_s.mbox[REG_REF_ID] = err;
					end else begin
						next_s.job_active = 1'b1;
						next_s.timer = 16'(JOB_CYCLES - 1);
						next_s.job_write = (s.mbox[REG_REF_ID][7:0] == REQ_ID_WRITE);
						next_s.job_ref = s.mbox[REG_REF_ID][15:8];
						next_s.job_obj = s.mbox[REG_OBJ_COUNT];
						next_s.job_pidx = PIDX_W'(s.mbox[REG_PNUM]);
						next_s.job_fmt = s.mbox[REG_FMT_COUNT][15:8];
						next_s.job_value = {s.mbox[REG_VALUE_HI], s.mbox[REG_VALUE_LO]};
						next_s.mbox[REG_CONTROL] = CTRL_ACTIVE;
						next_s.mbox[REG_FUNC_LEN] = {JOB_FUNC, LEN_ERROR};
						next_s.mbox[REG_REF_ID] = ERR_NOT_READY;
					end
				end
			end
			D_READ: begin
				// the full mailbox goes out whatever count was asked for
				next_s.rsp_valid = 1'b1;
				next_s.rsp_data = s.mbox[s.widx[3:0]];
				next_s.rsp_byte_count = RSP_BYTE_COUNT;
				next_s.rsp_last = (s.widx == 5'(MBOX_WORDS - 1));
				next_s.widx = s.widx + 5'd1;
				if (s.widx == 5'(MBOX_WORDS - 1))
					next_s.st = D_IDLE;
			end
		endcase

		// job engine runs beside the link so reads see progress
		if (s.job_active) begin
			if (s.timer != 16'h0000) begin
				next_s.timer = s.timer - 16'h0001;
			end else begin
				next_s.job_active = 1'b0;
				for (int i = REG_ATTR_ELEM; i < MBOX_WORDS; i++)
					next_s.mbox[i] = 16'h0000;
				next_s.mbox[REG_CONTROL] = CTRL_DONE;
				next_s.mbox[REG_OBJ_COUNT] = s.job_obj;
				if (s.job_write) begin
					next_s.params[s.job_pidx] = s.job_value;
					next_s.fmts[s.job_pidx] = s.job_fmt;
					next_s.mbox[REG_FUNC_LEN] = {JOB_FUNC, LEN_WRITE_RSP};
					next_s.mbox[REG_REF_ID] = {s.job_ref, REQ_ID_WRITE};
				end else begin
					next_s.mbox[REG_FUNC_LEN] = {JOB_FUNC, LEN_READ_RSP};
					next_s.mbox[REG_REF_ID] = {s.job_ref, REQ_ID_READ};
					next_s.mbox[REG_ATTR_ELEM] = {s.fmts[s.job_pidx], COUNT_ONE};
					next_s.mbox[REG_PNUM] = s.params[s.job_pidx][15:0];
				end
			end
		end
		next_s.job_busy = next_s.job_active;
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!nrst) begin
			s <= '0;
			for (int i = 0; i < PARAM_DEPTH; i++)
				s.fmts[i] <= FMT_RESET;
		end else begin
			s <= next_s;
		end
	end

	// outputs straight from the state flops
	assign link.req_ready = s.req_ready;
	assign link.rsp_valid = s.rsp_valid;
	assign link.rsp_data = s.rsp_data;
	assign link.rsp_byte_count = s.rsp_byte_count;
	assign link.rsp_last = s.rsp_last;
	assign link.rsp_exc = s.rsp_exc;
	assign job_busy = s.job_busy;

endmodule // mbpm_drive_end

// [mbpm_pkg.sv]
// shared constants and types for the parameter mailbox link
package mbpm_pkg;

	typedef logic [15:0] mbpm_word_t;

	// ------------------------------------------------------------
	// transaction codes and mailbox placement
	// ------------------------------------------------------------
	localparam logic [7:0]  FC_WRITE_MULTI = 8'h10;
	localparam logic [7:0]  FC_READ_HOLD   = 8'h03;
	localparam logic [15:0] MBOX_BASE      = 16'h0258;
	localparam int          MBOX_WORDS     = 16;
	localparam logic [7:0]  RSP_BYTE_COUNT = 8'h20;
	localparam int          REQ_WORDS_READ  = 7;
	localparam int          REQ_WORDS_WRITE = 10;

	// ------------------------------------------------------------
	// register index inside the mailbox (address = base + index)
	// ------------------------------------------------------------
	localparam int REG_CONTROL   = 0;
	localparam int REG_FUNC_LEN  = 1;
	localparam int REG_REF_ID    = 2;
	localparam int REG_OBJ_COUNT = 3;
	localparam int REG_ATTR_ELEM = 4;
	localparam int REG_PNUM      = 5;
	localparam int REG_SUBINDEX  = 6;
	localparam int REG_FMT_COUNT = 7;
	localparam int REG_VALUE_HI  = 8;
	localparam int REG_VALUE_LO  = 9;

	// ------------------------------------------------------------
	// field values
	// ------------------------------------------------------------
	localparam mbpm_word_t CTRL_FILL   = 16'h0000;
	localparam mbpm_word_t CTRL_ACTIVE = 16'h0001;
	localparam mbpm_word_t CTRL_DONE   = 16'h0002;
	localparam logic [7:0] JOB_FUNC      = 8'h2f;
	localparam logic [7:0] REQ_ID_READ   = 8'h01;
	localparam logic [7:0] REQ_ID_WRITE  = 8'h02;
	localparam logic [7:0] LEN_READ_REQ  = 8'h0a;
	localparam logic [7:0] LEN_WRITE_REQ = 8'h10;
	localparam logic [7:0] LEN_READ_RSP  = 8'h08;
	localparam logic [7:0] LEN_WRITE_RSP = 8'h04;
	localparam logic [7:0] LEN_ERROR     = 8'h00;
	localparam logic [7:0] ATTR_VALUE    = 8'h10;
	localparam logic [7:0] COUNT_ONE     = 8'h01;
	localparam logic [7:0] FMT_RESET     = 8'h03;
	localparam logic [7:0] REF_START     = 8'h80;
	localparam mbpm_word_t ERR_NONE      = 16'h0000;
	localparam mbpm_word_t ERR_LENGTH    = 16'h0001;
	localparam mbpm_word_t ERR_STATE     = 16'h0002;
	localparam mbpm_word_t ERR_FUNC      = 16'h0003;
	localparam mbpm_word_t ERR_NOT_READY = 16'h0004;
	localparam mbpm_word_t ERR_INTERNAL  = 16'h0005;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 40;
	localparam int JOB_TIME_NS   = 2000;
	localparam int JOB_CYCLES    = (JOB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int POLL_TIME_NS  = 1000;
	localparam int POLL_CYCLES   = (POLL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// [mbpm_link_if.sv]
// word-level holding-register link between controller and drive
`timescale 1ns/1ps
interface mbpm_link_if;
	logic               req_valid;
	logic [7:0]         req_fc;
	logic [15:0]        req_addr;
	logic [7:0]         req_count;
	logic               req_ready;
	logic               wr_valid;
	logic [15:0]        wr_data;
	logic               rsp_valid;
	logic [15:0]        rsp_data;
	logic [7:0]         rsp_byte_count;
	logic               rsp_last;
	logic               rsp_exc;

	modport dev (
		input  req_valid, req_fc, req_addr, req_count, wr_valid, wr_data,
		output req_ready, rsp_valid, rsp_data, rsp_byte_count, rsp_last, rsp_exc
	);
	modport ctl (
		output req_valid, req_fc, req_addr, req_count, wr_valid, wr_data,
		input  req_ready, rsp_valid, rsp_data, rsp_byte_count, rsp_last, rsp_exc
	);
endinterface

// [mbpm_ctrl_end.sv]
// controller end: issues a parameter job and polls for its result
`timescale 1ns/1ps
module mbpm_ctrl_end #(
	parameter int POLL_CYCLES = mbpm_pkg::POLL_CYCLES
) (
	input  wire logic               clk,
	input  wire logic               nrst,
	mbpm_link_if.ctl                link,
	input  wire logic               start,
	input  wire logic               write_job,
	input  wire logic [7:0]         drive_object_id,
	input  wire mbpm_pkg::mbpm_word_t param_number,
	input  wire mbpm_pkg::mbpm_word_t param_subindex,
	input  wire logic [7:0]         value_format,
	input  wire logic [31:0]        value,
	output logic                    busy,
	output logic                    done,
	output logic                    ok,
	output mbpm_pkg::mbpm_word_t    error_code,
	output mbpm_pkg::mbpm_word_t    read_value
);
	import mbpm_pkg::*;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef enum logic [2:0] {C_IDLE, C_REQ, C_WDATA, C_WACK, C_GAP, C_POLL, C_RX} mbpm_cst_t;

	typedef struct packed {
		mbpm_cst_t            st;
		mbpm_cst_t            after_req;
		logic [4:0]           widx;
		logic [15:0]          gap;
		logic                 wr;
		logic [7:0]           ref_id;
		logic [7:0]           obj;
		mbpm_word_t           pnum;
		mbpm_word_t           sub;
		logic [7:0]           fmt;
		logic [31:0]          val;
		mbpm_word_t [5:0]     rx;
		logic                 req_valid;
		logic [7:0]           req_fc;
		logic [15:0]          req_addr;
		logic [7:0]           req_count;
		logic                 wr_valid;
		mbpm_word_t           wr_data;
		logic                 busy;
		logic                 done;
		logic                 ok;
		mbpm_word_t           error_code;
		mbpm_word_t           read_value;
	} mbpm_ctl_state_t;

	mbpm_ctl_state_t s;
	mbpm_ctl_state_t next_s;

	// ------------------------------------------------------------
	// request block word by index
	// ------------------------------------------------------------
	function automatic mbpm_word_t req_word(input mbpm_ctl_state_t c, input logic [4:0] i);
		case (i)
			5'd0: return CTRL_ACTIVE;
			5'd1: return {JOB_FUNC, c.wr ? LEN_WRITE_REQ : LEN_READ_REQ};
			5'd2: return {c.ref_id, c.wr ? REQ_ID_WRITE : REQ_ID_READ};
			5'd3: return {c.obj, COUNT_ONE};
			5'd4: return {ATTR_VALUE, COUNT_ONE};
			5'd5: return c.pnum;
			5'd6: return c.sub;
			5'd7: return {c.fmt, COUNT_ONE};
			5'd8: return c.val[31:16];
			5'd9: return c.val[15:0];
			default: return 16'h0000;
		endcase
	endfunction

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		next_s = s;
		next_s.done = 1'b0;
		next_s.wr_valid = 1'b0;
		unique case (s.st)
			C_IDLE: begin
				if (start) begin
					next_s.wr = write_job;
					next_s.obj = drive_object_id;
					next_s.pnum = param_number;
					next_s.sub = param_subindex;
					next_s.fmt = value_format;
					next_s.val = value;
					next_s.busy = 1'b1;
					next_s.req_valid = 1'b1;
					next_s.req_fc = FC_WRITE_MULTI;
					next_s.req_addr = MBOX_BASE;
					next_s.req_count = write_job ? 8'(REQ_WORDS_WRITE) : 8'(REQ_WORDS_READ);
					next_s.after_req = C_WDATA;
					next_s.st = C_REQ;
				end
			end
			C_REQ: begin
				if (link.req_ready) begin
					next_s.req_valid = 1'b0;
					next_s.st = s.after_req;
					if (s.after_req == C_WDATA) begin
						next_s.wr_valid = 1'b1;
						next_s.wr_data = req_word(s, 5'd0);
						next_s.widx = 5'd1;
					end
				end
			end
			C_WDATA: begin
				if (s.widx == 5'(s.req_count)) begin
					next_s.st = C_WACK;
				end else begin
					next_s.wr_valid = 1'b1;
					next_s.wr_data = req_word(s, s.widx);
					next_s.widx = s.widx + 5'd1;
				end
			end
			C_WACK: begin
				if (link.rsp_valid && link.rsp_last) begin
					if (link.rsp_exc) begin
						next_s.st = C_IDLE;
						next_s.busy = 1'b0;
						next_s.done = 1'b1;
						next_s.ok = 1'b0;
						next_s.error_code = ERR_INTERNAL;
					end else begin
						next_s.st = C_POLL;
					end
				end
			end
			C_GAP: begin
				next_s.gap = s.gap - 16'h0001;
				if (s.gap == 16'h0000)
					next_s.st = C_POLL;
			end
			C_POLL: begin
				next_s.req_valid = 1'b1;
				next_s.req_fc = FC_READ_HOLD;
				next_s.req_addr = MBOX_BASE;
				next_s.req_count = 8'(MBOX_WORDS);
				next_s.after_req = C_RX;
				next_s.widx = 5'd0;
				next_s.st = C_REQ;
			end
			C_RX: begin
				if (link.rsp_valid) begin
					if (s.widx < 5'd6)
						next_s.rx[s.widx[2:0]] = link.rsp_data;
					next_s.widx = s.widx + 5'd1;
					if (link.rsp_last) begin
						// anything short of control 2 is polled again
						if (!link.rsp_exc && s.rx[REG_CONTROL] == CTRL_DONE) begin
							next_s.st = C_IDLE;
							next_s.busy = 1'b0;
							next_s.done = 1'b1;
							next_s.ok = (s.rx[REG_FUNC_LEN][7:0] != LEN_ERROR);
							next_s.error_code = (s.rx[REG_FUNC_LEN][7:0] != LEN_ERROR)
								? ERR_NONE : s.rx[REG_REF_ID];
							next_s.read_value = s.rx[REG_PNUM];
							next_s.ref_id = s.ref_id + 8'h01;
						end else begin
							next_s.gap = 16'(POLL_CYCLES - 1);
							next_s.st = C_GAP;
						end
					end
				end
			end
			default: next_s.st = C_IDLE;
		endcase
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!nrst) begin
			s <= '0;
			s.ref_id <= REF_START;
		end else begin
			s <= next_s;
		end
	end

	// outputs straight from the state flops
	assign link.req_valid = s.req_valid;
	assign link.req_fc = s.req_fc;
	assign link.req_addr = s.req_addr;
	assign link.req_count = s.req_count;
	assign link.wr_valid = s.wr_valid;
	assign link.wr_data = s.wr_data;
	assign busy = s.busy;
	assign done = s.done;
	assign ok = s.ok;
	assign error_code = s.error_code;
	assign read_value = s.read_value;

endmodule // mbpm_ctrl_end

// [mbpm_link_asserts.sv]
// assertions watching the parameter mailbox link between both ends
`timescale 1ns/1ps
module mbpm_link_asserts (
	input wire logic        clk,
	input wire logic        nrst,
	input wire logic        req_valid,
	input wire logic [7:0]  req_fc,
	input wire logic [15:0] req_addr,
	input wire logic        req_ready,
	input wire logic        rsp_valid,
	input wire logic [15:0] rsp_data,
	input wire logic [7:0]  rsp_byte_count,
	input wire logic        rsp_last,
	input wire logic        rsp_exc
);
	import mbpm_pkg::*;

	logic [4:0] beat;
	logic       first_rd;

	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);

	// ------------------------------------------------------------
	// beat tracking
	// ------------------------------------------------------------
	// beat index inside one answer, restarted after its last beat
	always_ff @(posedge clk) begin
		if (!nrst || (rsp_valid && rsp_last)) begin
			beat <= 5'h00;
		end else if (rsp_valid) begin
			beat <= beat + 5'h01;
		end
	end
	// first beat of a mailbox read; anchors the content checks
	assign first_rd = rsp_valid && (beat == 5'h00) && (rsp_byte_count == RSP_BYTE_COUNT);

	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	property p_take_drops;
		req_valid && req_ready |=> !req_ready;
	endproperty
	a_take_drops: assert property (p_take_drops) else $error("ready stayed high after a taken request");

	property p_rd_start;
		req_valid && req_ready && (req_fc == FC_READ_HOLD) && (req_addr == MBOX_BASE) |-> ##[1:3] first_rd;
	endproperty
	a_rd_start: assert property (p_rd_start) else $error("mailbox read not answered in time");

	property p_rd_len;
		first_rd |-> (rsp_valid && !rsp_last)[*8] ##1 (rsp_valid && !rsp_last)[*7] ##1 (rsp_valid && rsp_last && !rsp_exc);
	endproperty
	a_rd_len: assert property (p_rd_len) else $error("mailbox read not sixteen beats");

	property p_wr_ack;
		req_valid && req_ready && (req_fc == FC_WRITE_MULTI) && (req_addr == MBOX_BASE)
			|-> ##[2:20] (rsp_last && !rsp_exc && (rsp_byte_count == 8'h00));
	endproperty
	a_wr_ack: assert property (p_wr_ack) else $error("mailbox write not acknowledged cleanly");

	property p_ctrl;
		first_rd |-> (rsp_data == CTRL_ACTIVE) || (rsp_data == CTRL_DONE);
	endproperty
	a_ctrl: assert property (p_ctrl) else $error("control word neither busy nor done");

	property p_busy;
		first_rd && (rsp_data == CTRL_ACTIVE) |=> (rsp_data == 16'h2f00) ##1 (rsp_data == ERR_NOT_READY);
	endproperty
	a_busy: assert property (p_busy) else $error("busy answer content wrong");

	property p_rd_ok;
		first_rd && (rsp_data == CTRL_DONE) ##1 (rsp_data == 16'h2f08)
			|=> (rsp_data[7:0] == REQ_ID_READ) && (rsp_data[15:8] >= REF_START) ##1 (rsp_data[7:0] == COUNT_ONE);
	endproperty
	a_rd_ok: assert property (p_rd_ok) else $error("read answer identifier wrong");

	property p_wr_ok;
		first_rd && (rsp_data == CTRL_DONE) ##1 (rsp_data == 16'h2f04)
			|=> (rsp_data[7:0] == REQ_ID_WRITE) ##1 (rsp_data[7:0] == COUNT_ONE) ##1 (rsp_data == 16'h0000);
	endproperty
	a_wr_ok: assert property (p_wr_ok) else $error("write answer content wrong");

	property p_err;
		first_rd && (rsp_data == CTRL_DONE) ##1 (rsp_data == 16'h2f00)
			|=> (rsp_data >= ERR_LENGTH) && (rsp_data <= ERR_INTERNAL);
	endproperty
	a_err: assert property (p_err) else $error("error answer code out of range");

endmodule // mbpm_link_asserts

// [tb_top.sv]
// self-checking bench joining the controller end to the drive end
`timescale 1ns/1ps
module tb_top;
	import mbpm_pkg::*;

	logic        clk, nrst, start, write_job, drive_locked, job_busy, busy, done, ok;
	logic [7:0]  drive_object_id, value_format;
	mbpm_word_t  param_number, param_subindex, error_code, read_value;
	logic [31:0] value;
	int          mismatches, total_checks, cycles, busy_cycles;

	// job length handed to the drive end; also the expected busy span
	localparam int TB_JOB_CYCLES = 30;

	mbpm_link_if link ();

	mbpm_drive_end #(.PARAM_DEPTH(16), .JOB_CYCLES(TB_JOB_CYCLES)) u_mbpm_drive_end (.clk(clk), .nrst(nrst),
		.link(link.dev), .drive_locked(drive_locked), .job_busy(job_busy));
	mbpm_ctrl_end #(.POLL_CYCLES(2)) u_mbpm_ctrl_end (.clk(clk), .nrst(nrst), .link(link.ctl),
		.start(start), .write_job(write_job), .drive_object_id(drive_object_id),
		.param_number(param_number), .param_subindex(param_subindex), .value_format(value_format),
		.value(value), .busy(busy), .done(done), .ok(ok), .error_code(error_code), .read_value(read_value));
	mbpm_link_asserts u_mbpm_link_asserts (.clk(clk), .nrst(nrst), .req_valid(link.req_valid),
		.req_fc(link.req_fc), .req_addr(link.req_addr), .req_ready(link.req_ready),
		.rsp_valid(link.rsp_valid), .rsp_data(link.rsp_data), .rsp_byte_count(link.rsp_byte_count),
		.rsp_last(link.rsp_last), .rsp_exc(link.rsp_exc));

	// ------------------------------------------------------------
	// clock and hang guard
	// ------------------------------------------------------------
	initial clk = 1'b0;
	always #20 clk = ~clk;
	// whole run needs a few hundred cycles; a stuck job ends here
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			results();
		end
	end

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic results;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// one job from start pulse to done; bounded wait on done
	task automatic run_job(input logic wr, input mbpm_word_t pnum, input logic [31:0] val);
		int n;
		@(negedge clk);
		write_job = wr;
		param_number = pnum;
		value = val;
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
		busy_cycles = 0;
		check({31'h0, busy}, 32'h1);
		for (n = 0; n < 600 && done !== 1'b1; n++) begin
			@(posedge clk);
			#1;
			if (job_busy === 1'b1)
				busy_cycles++;
		end
		check({31'h0, done}, 32'h1);
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic test_read_default;
		run_job(1'b0, 16'h0002, 32'h0);
		check({31'h0, ok}, 32'h1);
		check({16'h0, error_code}, {16'h0, ERR_NONE});
		check({16'h0, read_value}, 32'h0);
		check(32'(busy_cycles), 32'(TB_JOB_CYCLES));
		$display("test_read_default done");
	endtask

	task automatic test_write_read;
		run_job(1'b1, 16'h0002, 32'h4142_6666);
		check({31'h0, ok}, 32'h1);
		check({16'h0, error_code}, {16'h0, ERR_NONE});
		run_job(1'b0, 16'h0002, 32'h0);
		check({16'h0, read_value}, 32'h6666);
		run_job(1'b0, 16'h0003, 32'h0);
		check({16'h0, read_value}, 32'h0);
		$display("test_write_read done");
	endtask

	task automatic test_locked;
		@(negedge clk);
		drive_locked = 1'b1;
		run_job(1'b1, 16'h0004, 32'h0000_1234);
		check({31'h0, ok}, 32'h0);
		check({16'h0, error_code}, {16'h0, ERR_STATE});
		check(32'(busy_cycles), 32'h0);
		@(negedge clk);
		drive_locked = 1'b0;
		run_job(1'b0, 16'h0004, 32'h0);
		check({16'h0, read_value}, 32'h0);
		$display("test_locked done");
	endtask

	task automatic test_bad_param;
		run_job(1'b0, 16'h0010, 32'h0);
		check({31'h0, ok}, 32'h0);
		check({16'h0, error_code}, {16'h0, ERR_INTERNAL});
		check(32'(busy_cycles), 32'h0);
		$display("test_bad_param done");
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		nrst = 1'b0;
		start = 1'b0;
		write_job = 1'b0;
		drive_locked = 1'b0;
		drive_object_id = 8'h01;
		param_number = 16'h0000;
		param_subindex = 16'h0000;
		value_format = 8'h08;
		value = 32'h0;
		repeat (8) @(posedge clk);
		@(negedge clk);
		nrst = 1'b1;
		test_read_default();
		test_write_read();
		test_locked();
		test_bad_param();
		results();
	end

endmodule // tb_top
